// ===== ssp_assertions.sv
// Purpose: port-level checks for the serial port top
// Assumes: one clock domain, rstn async active low
// Notes:   sees the top ports only, bound from the bench
`timescale 1ns/1ps
module ssp_assertions (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sck_out
);
	// ----------------
	// checks
	// ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic rd_ok, mapped;
	assign rd_ok  = pready && !pwrite;
	assign mapped = paddr inside {ssp_pkg::SSP_OFF_CTRL,
		ssp_pkg::SSP_OFF_STAT, ssp_pkg::SSP_OFF_DATA, ssp_pkg::SSP_OFF_PORTB};
	sequence access_wait;
		psel && penable && !pready;
	endsequence
	// an abort only raises the clock, so with the port enabled a long low phase is a fault
	sequence low_twice;
		$fell(sck_out) ##1 !sck_out;
	endsequence
	ready_after_a: assert property (access_wait |=> pready)
		else $error("no ready after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	err_map_a: assert property (pready |-> pslverr == !mapped)
		else $error("error response wrong for address");
	upper_zero_a: assert property (rd_ok |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	ctrl_zero_a: assert property (rd_ok && paddr == ssp_pkg::SSP_OFF_CTRL
		|-> (prdata[7:0] & 8'hAF) == 8'h00) else $error("ctrl unused set");
	stat_zero_a: assert property (rd_ok && paddr == ssp_pkg::SSP_OFF_STAT
		|-> prdata[5:0] == 6'h00) else $error("status unused set");
	sck_low_a: assert property (low_twice |=> sck_out)
		else $error("clock low phase too long");
	sck_high_a: assert property ($rose(sck_out) |=> sck_out)
		else $error("clock high phase too short");
endmodule // ssp_assertions

// ===== ssp_partner.sv
// Purpose: shift register standing on the far side of the link
// Assumes: clock idles high; change on fall, sample on rise
// Notes:   has no rate of its own, the clock source sets it
`timescale 1ns/1ps
module ssp_partner (
	input  wire logic       sck,
	input  wire logic       din,
	input  wire logic       ld,
	input  wire logic [7:0] load,
	output logic            dout,
	output logic [7:0]      got
);
	// ----------------
	// shifter
	// ----------------
	initial dout = 1'b1;
	always @(posedge sck or posedge ld) begin
		if (ld)
			got <= load;
		else
			got <= {got[6:0], din};
	end
	always @(negedge sck) dout <= got[7];
endmodule // ssp_partner

// ===== ssp_pkg.sv
// Purpose: constants for the simple synchronous serial port
// Assumes: apb slave with 32-bit data, one register per aligned word
// Notes:   offsets are byte addresses
package ssp_pkg;
	localparam logic [11:0] SSP_OFF_CTRL   = 12'h000;
	localparam logic [11:0] SSP_OFF_STAT   = 12'h004;
	localparam logic [11:0] SSP_OFF_DATA   = 12'h008;
	localparam logic [11:0] SSP_OFF_PORTB  = 12'h00C;
	localparam int          SSP_CTRL_EN    = 6;
	localparam int          SSP_CTRL_MASTER_SELECT_BIT  = 4;
	localparam int          SSP_STAT_DONE  = 7;
	localparam int          SSP_STAT_COL   = 6;
	localparam int          SSP_PB_LATCH   = 0;
	localparam int          SSP_PB_DIR     = 1;
	localparam logic [7:0]  SSP_CTRL_RST   = 8'h00;
	localparam logic [7:0]  SSP_DATA_RST   = 8'h00;
	localparam logic [1:0]  SSP_DIV_HALF   = 2'h1;
	localparam logic [3:0]  SSP_BITS       = 4'h8;
	localparam bit          SSP_MSB_FIRST  = 1'b1;
	typedef enum logic [1:0] {
		SSP_IDLE = 2'b00,
		SSP_LOW  = 2'b01,
		SSP_HIGH = 2'b10
	} ssp_state_t;
endpackage

// ===== ssp_sync.sv
// Purpose: two flip-flop synchroniser for the pin inputs
// Assumes: inputs asynchronous to clk
// Notes:   first stage is read by the second only
`timescale 1ns/1ps
module ssp_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;
	// --------------------------------------------------------------
	// per-bit synchroniser chain
	// --------------------------------------------------------------
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				meta_q[i] <= 1'b1;
				q[i]      <= 1'b1;
			end else if (ce) begin
				meta_q[i] <= d[i];
				q[i]      <= meta_q[i];
			end
		end
	end
endmodule // ssp_sync

// ===== ssp_top.sv
// Purpose: simple 8-bit synchronous serial port with apb registers
// Assumes: clk 25 MHz; link clock sampled in clk domain
// Notes:   shift order fixed by SSP_MSB_FIRST
`timescale 1ns/1ps
module ssp_top (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe_n,
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin,
	output logic             serial_out_oe_n,
	input  wire logic        port_b_bit7_gpio,
	input  wire logic        port_b_bit7_dir
);
	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	ssp_pkg::ssp_state_t state_q, state_d;
	logic [7:0] shift_q;
	logic [3:0] cnt_q;
	logic [1:0] div_q;
	logic       en_q, master_select_bit_q, done_q, col_q;
	logic       latch_q, dir_q, sout_q;
	logic       stat_seen_q, col_off_q;
	logic       sck_gen_q, sck_prev_q;
	logic       samp_q, samp_last_q;
	logic [1:0] pins_s;
	logic [31:0] prdata_q;
	// --------------------------------------------------------------
	// pin synchronisers
	// --------------------------------------------------------------
	ssp_sync #(.W(2)) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.d    ({sck_in, serial_in_pin}),
		.q    (pins_s)
	);
	// --------------------------------------------------------------
	// apb decode
	// --------------------------------------------------------------
	// side effects land once, at the edge where pready is seen high
	wire acc      = psel && penable && pready;
	wire wr       = acc && pwrite;
	wire rd       = acc && !pwrite;
	wire hit_ctrl = paddr == ssp_pkg::SSP_OFF_CTRL;
	wire hit_stat = paddr == ssp_pkg::SSP_OFF_STAT;
	wire hit_data = paddr == ssp_pkg::SSP_OFF_DATA;
	wire hit_pb   = paddr == ssp_pkg::SSP_OFF_PORTB;
	wire unmapped = !(hit_ctrl || hit_stat || hit_data || hit_pb);
	wire data_acc = acc && hit_data && en_q;
	wire ctrl_wr  = wr && hit_ctrl;
	wire new_en   = pwdata[ssp_pkg::SSP_CTRL_EN];
	wire new_master_select_bit = pwdata[ssp_pkg::SSP_CTRL_MASTER_SELECT_BIT];
	// abort on disable or on leaving master mode
	wire abort    = (ctrl_wr && !new_en) ||
	                (ctrl_wr && master_select_bit_q && !new_master_select_bit);
	wire busy     = state_q == ssp_pkg::SSP_HIGH ||
	                (state_q == ssp_pkg::SSP_LOW);
	// --------------------------------------------------------------
	// serial clock edges
	// --------------------------------------------------------------
	// slave clock only seen through synchroniser; rate bound by partner
	wire sck_now  = master_select_bit_q ? sck_gen_q : pins_s[1];
	wire fall     = en_q && sck_prev_q && !sck_now;
	wire rise     = en_q && !sck_prev_q && sck_now;
	wire last_bit = rise && cnt_q == ssp_pkg::SSP_BITS - 4'h1;
	wire start    = fall && state_q == ssp_pkg::SSP_IDLE;
	wire master_select_bit_go  = wr && hit_data && en_q && master_select_bit_q &&
	                state_q == ssp_pkg::SSP_IDLE;
	wire out_bit  = ssp_pkg::SSP_MSB_FIRST ? shift_q[7] : shift_q[0];
	wire [7:0] shifted = ssp_pkg::SSP_MSB_FIRST ?
	                {shift_q[6:0], pins_s[0]} : {pins_s[0], shift_q[7:1]};
	// own clock is seen at once but input data lags two flops: delay sample
	wire samp      = master_select_bit_q ? samp_q : (rise && busy);
	wire samp_last = master_select_bit_q ? samp_last_q : last_bit;
	wire sout_d    = !en_q ? latch_q :
	                 fall ? out_bit :
	                 samp_last ? pins_s[0] : sout_q;
	// --------------------------------------------------------------
	// transfer state machine
	// --------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			ssp_pkg::SSP_IDLE: if (start || master_select_bit_go) begin
				state_d = ssp_pkg::SSP_LOW;
			end
			ssp_pkg::SSP_LOW:  if (rise) begin
				state_d = last_bit ? ssp_pkg::SSP_IDLE : ssp_pkg::SSP_HIGH;
			end
			ssp_pkg::SSP_HIGH: if (fall) begin
				state_d = ssp_pkg::SSP_LOW;
			end
			default:           state_d = ssp_pkg::SSP_IDLE;
		endcase
		if (abort || !en_q) begin
			state_d = ssp_pkg::SSP_IDLE;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q    <= ssp_pkg::SSP_IDLE;
			cnt_q      <= 4'h0;
			div_q      <= 2'h0;
			sck_gen_q  <= 1'b1;
			sck_prev_q <= 1'b1;
			samp_q      <= 1'b0;
			samp_last_q <= 1'b0;
		end else if (ce) begin
			state_q    <= state_d;
			sck_prev_q <= sck_now;
			samp_q      <= rise && busy && master_select_bit_q;
			samp_last_q <= last_bit && master_select_bit_q;
			if (abort || !en_q || state_d == ssp_pkg::SSP_IDLE) begin
				cnt_q <= 4'h0;
			end else if (rise) begin
				cnt_q <= cnt_q + 4'h1;
			end
			// quarter-rate clock: toggle every second clk cycle
			if (!master_select_bit_q || state_d == ssp_pkg::SSP_IDLE) begin
				div_q     <= 2'h0;
				sck_gen_q <= 1'b1;
			end else if (div_q == ssp_pkg::SSP_DIV_HALF) begin
				div_q     <= 2'h0;
				sck_gen_q <= !sck_gen_q;
			end else begin
				div_q <= div_q + 2'h1;
			end
		end
	end
	// --------------------------------------------------------------
	// data register, shifter and output stage
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shift_q <= ssp_pkg::SSP_DATA_RST;
			sout_q  <= 1'b1;
		end else if (ce) begin
			if (wr && data_acc) begin
				shift_q <= pwdata[7:0];
			end else if (samp) begin
				shift_q <= shifted;
			end
			sout_q <= sout_d;
		end
	end
	// --------------------------------------------------------------
	// control, port b latch and flags
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			en_q        <= 1'b0;
			master_select_bit_q      <= 1'b0;
			latch_q     <= 1'b1;
			dir_q       <= 1'b0;
			done_q      <= 1'b0;
			col_q       <= 1'b0;
			stat_seen_q <= 1'b0;
			col_off_q   <= 1'b0;
		end else if (ce) begin
			if (ctrl_wr) begin
				en_q   <= new_en;
				master_select_bit_q <= new_master_select_bit;
			end
			if (wr && hit_pb) begin
				latch_q <= pwdata[ssp_pkg::SSP_PB_LATCH];
				dir_q   <= pwdata[ssp_pkg::SSP_PB_DIR];
			end
			if (rd && hit_stat) begin
				stat_seen_q <= done_q;
			end else if (data_acc) begin
				stat_seen_q <= 1'b0;
			end
			if (ctrl_wr && !new_en && !done_q) begin
				col_off_q <= col_q;
			end else if (ctrl_wr && new_en) begin
				col_off_q <= 1'b0;
			end
			// set beats clear for both flags
			if (last_bit) begin
				done_q <= 1'b1;
			end else if (data_acc && stat_seen_q) begin
				done_q <= 1'b0;
			end
			if ((data_acc && busy) ||
			    (start && (stat_seen_q || col_off_q))) begin
				col_q <= 1'b1;
			end else if (data_acc && stat_seen_q) begin
				col_q <= 1'b0;
			end else if (ctrl_wr && new_en && col_off_q) begin
				col_q <= 1'b0;
			end
		end
	end
	// --------------------------------------------------------------
	// read mux and pin drivers
	// --------------------------------------------------------------
	wire [7:0] ctrl_rd = {1'b0, en_q, 1'b0, master_select_bit_q, 4'h0};
	wire [7:0] stat_rd = {done_q, col_q, 6'h00};
	wire [7:0] data_rd = en_q ? shift_q : 8'h00;
	wire [7:0] pb_rd   = {6'h00, dir_q, latch_q};
	wire [7:0] rd_mux  = hit_ctrl ? ctrl_rd :
	                     hit_stat ? stat_rd :
	                     hit_data ? data_rd :
	                     hit_pb   ? pb_rd   : 8'h00;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata_q        <= 32'h0000_0000;
			pready          <= 1'b0;
			pslverr         <= 1'b0;
			sck_out         <= 1'b1;
			sck_oe_n        <= 1'b1;
			serial_out_pin  <= 1'b1;
			serial_out_oe_n <= 1'b1;
		end else if (ce) begin
			// one wait state: answer on the second access cycle
			pready   <= psel && penable && !pready;
			pslverr  <= psel && penable && !pready && unmapped;
			prdata_q <= {24'h000000, rd_mux};
			sck_out  <= en_q ? sck_gen_q : port_b_bit7_gpio;
			sck_oe_n <= en_q ? !master_select_bit_q : !port_b_bit7_dir;
			// pin follows the next value so a slave clock gets it in time
			serial_out_pin  <= sout_d;
			serial_out_oe_n <= !(en_q ? 1'b1 : dir_q);
		end
	end
	assign prdata = prdata_q;
endmodule // ssp_top

// ===== test_simple_sync_serial_port.sv
// Purpose: self-checking bench for the serial port
// Assumes: apb master here, partner shift register on the link
// Notes:   fixed seed; link clock of 320 ns in slave mode
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
	$display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module test_simple_sync_serial_port;
	// ----------------
	// harness
	// ----------------
	localparam logic [11:0] AC = ssp_pkg::SSP_OFF_CTRL;
	localparam logic [11:0] AS = ssp_pkg::SSP_OFF_STAT;
	localparam logic [11:0] AD = ssp_pkg::SSP_OFF_DATA;
	logic        clk, pready, pslverr, sck_out, sck_oe_n, so, so_oe_n, pin_in;
	logic        rstn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic        sclk_b = 1, pld = 0, out_last = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic [7:0]  rd, pgot, d, p, pload = 0;
	int          errors = 0, cmp_count = 0, i;
	wire         sck_w = sck_oe_n ? sclk_b : sck_out;
	// a released line shows the inverse of its last level
	wire         line_out = so_oe_n ? ~out_last : so;
	ssp_top dut (.clk(clk), .rstn(rstn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_w),
		.sck_out(sck_out), .sck_oe_n(sck_oe_n), .serial_in_pin(pin_in),
		.serial_out_pin(so), .serial_out_oe_n(so_oe_n),
		.port_b_bit7_gpio(1'b1), .port_b_bit7_dir(1'b0));
	ssp_partner far (.sck(sck_w), .din(line_out), .ld(pld), .load(pload),
		.dout(pin_in), .got(pgot));
	always @(posedge clk) if (!so_oe_n) out_last <= so;
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#3000000;
		hang();
	end
	function automatic logic [7:0] st(input logic dn, input logic cl);
		return {dn, cl, 6'h00};
	endfunction
	task automatic finish_test;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic hang;
		errors++;
		finish_test();
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, v};
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 40) hang();
	endtask
	task automatic wait_fall;
		int n;
		for (n = 0; n < 100 && sck_out !== 1'b0; n++) @(posedge clk);
		if (n == 100) hang();
	endtask
	task automatic wait_done;
		int n;
		for (n = 0; n < 30; n++) begin
			apb(1'b0, AS, 8'h00);
			if (rd[7] === 1'b1) break;
		end
		if (n == 30) hang();
	endtask
	task automatic start(input logic [7:0] fv, input logic [7:0] dv);
		@(posedge clk);
		pload <= fv;
		pld <= 1'b1;
		@(posedge clk);
		pld <= 1'b0;
		apb(1'b1, AD, dv);
	endtask
	task automatic xfer(input logic slave);
		start(p, d);
		if (slave) begin
			repeat (8) begin
				repeat (4) @(posedge clk);
				sclk_b <= 1'b0;
				repeat (4) @(posedge clk);
				sclk_b <= 1'b1;
			end
		end
		wait_done();
		`CHK(rd, st(1'b1, 1'b0))
		apb(1'b0, AD, 8'h00);
		`CHK(rd, p)
		`CHK(pgot, d)
		apb(1'b0, AS, 8'h00);
		`CHK(rd, st(1'b0, 1'b0))
	endtask
	// ----------------
	// scenarios
	// ----------------
	initial begin
		void'($urandom(32'hF170737F));
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, AS, 8'h00);
		`CHK(rd, st(1'b0, 1'b0))
		apb(1'b1, ssp_pkg::SSP_OFF_PORTB, 8'h02);
		repeat (3) @(negedge clk);
		`CHK({so_oe_n, so}, 2'b00)
		apb(1'b1, ssp_pkg::SSP_OFF_PORTB, 8'h03);
		apb(1'b1, AC, 8'hFF);
		repeat (3) @(negedge clk);
		`CHK(so, 1'b1)
		`CHK({so_oe_n, sck_oe_n}, 2'b00)
		apb(1'b0, AC, 8'h00);
		`CHK(rd, 8'h50)
		for (i = 0; i < 4; i++) begin
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
			p = (i < 2) ? ~d : 8'($urandom);
			xfer(1'b0);
		end
		start(8'h3C, 8'hC3);
		wait_fall();
		apb(1'b1, AD, 8'h5A);
		wait_done();
		`CHK(rd, st(1'b1, 1'b1))
		apb(1'b0, AD, 8'h00);
		apb(1'b0, AS, 8'h00);
		`CHK(rd, st(1'b0, 1'b0))
		start(8'h00, 8'h81);
		wait_fall();
		apb(1'b0, AD, 8'h00);
		apb(1'b1, AC, 8'h00);
		repeat (2) @(negedge clk);
		`CHK(sck_oe_n, 1'b1)
		apb(1'b0, AD, 8'h00);
		`CHK(rd, 8'h00)
		apb(1'b0, AS, 8'h00);
		`CHK(rd, st(1'b0, 1'b1))
		apb(1'b1, AC, 8'h50);
		apb(1'b0, AS, 8'h00);
		`CHK(rd, st(1'b0, 1'b0))
		start(8'h00, 8'h81);
		wait_fall();
		apb(1'b1, AC, 8'h40);
		repeat (40) @(posedge clk);
		// clock pin hand-over can look like a slave edge: restart the port
		apb(1'b1, AC, 8'h00);
		apb(1'b1, AC, 8'h40);
		apb(1'b1, AS, 8'hFF);
		apb(1'b0, AS, 8'h00);
		`CHK(rd, st(1'b0, 1'b0))
		`CHK(sck_oe_n, 1'b1)
		d = 8'($urandom);
		p = 8'($urandom);
		xfer(1'b1);
		apb(1'b0, 12'h010, 8'h00);
		`CHK({er, rd}, 9'h100)
		finish_test();
	end
endmodule // test_simple_sync_serial_port
bind ssp_top ssp_assertions chk (.clk(clk), .rstn(rstn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sck_out(sck_out));
